// ===== hdl/tsi_pkg.sv
// Purpose: Shared constants and types for the time slot interchange switch
// Assumes: One core clock; serial clock arrives as a synchronous level input
// Notes:   Connection word layout is held here so the bench can build entries
package tsi_pkg;
  localparam int         NUM_STREAMS   = 8;
  localparam int         CH_PER_FRAME  = 32;
  localparam int         BITS_PER_CH   = 8;
  localparam int         SCLK_PER_BIT  = 2;
  localparam int         SRC_LSB       = 0;
  localparam int         SRC_W         = 8;
  localparam int         CM_PROC_BIT   = 8;
  localparam int         CM_CONST_BIT  = 9;
  localparam int         CM_HIZ_BIT    = 10;
  localparam int         CM_W          = 16;
  localparam logic       IDLE_LVL_RST  = 1'b1;
  localparam logic [7:0] FS_LEARN_BIT  = 8'h80;
  localparam logic [7:0] BIT_CNT_RST   = 8'h00;
  localparam logic [7:0] BLK_LAST_ADDR = 8'hff;
  typedef enum logic [1:0] {ACK_IDLE, ACK_LOW, ACK_HIGH} tsi_ack_t;
endpackage

// ===== hdl/tsi_switch.sv
// Purpose: Time slot interchange switch, eight serial streams, host port
// Assumes: All pins synchronous to core_clk; serial_clk is a sampled level
// Notes:   Memories are not cleared by reset, only registers, shift and data registers included
// Operation
// - Route any of 256 inputs to 256 outputs
// - Eight serial inputs, eight matching serial outputs
// - Per-channel variable or constant throughput delay
// - Per-stream programmable input frame offset
// - Measure frame offset via frame evaluation input
// - Per-channel high impedance output slot
// - Per-channel processor mode sends host data
// - Block programming fills whole connection memory
// - Detect frame sync polarity, pick format
// - Single 4.096 MHz serial clock shifts data
// - Reset clears state, floats serial and data
// - Non-multiplexed style uses dedicated address lines
// - Multiplexed direction style: strobe active high
// - Non-multiplexed style: strobe active low
// - Separate-strobe read strobe drives data bus
// - Direction input selects read or write
// - Separate-strobe write strobe takes data in
// - Chip select low enables, else strobes other than address latch ignored
// - Style select high means multiplexed port
// - Acknowledge low on completion, high, then released
// - Frame holds 32 eight-bit channel slots
// - Drive enable high enables serial outputs
`timescale 1ns/100ps
module tsi_switch #(
  parameter int NS    = tsi_pkg::NUM_STREAMS,
  parameter int OFS_W = 3
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic                     serial_clk,
  input  wire logic [NS-1:0]            serial_in_streams,
  output logic      [NS-1:0]            serial_out_streams,
  output logic      [NS-1:0]            serial_out_oe,
  input  wire logic                     serial_drive_enable,
  input  wire logic                     frame_sync_in,
  output logic                          frame_format_gci,
  input  wire logic                     frame_eval_in,
  input  wire logic                     eval_start,
  output logic                          eval_done,
  output logic      [8:0]               eval_result,
  input  wire logic [NS-1:0][OFS_W-1:0] stream_offsets,
  input  wire logic                     block_prog_start,
  input  wire logic [15:0]              block_prog_word,
  output logic                          block_prog_busy,
  input  wire logic                     host_style_select,
  input  wire logic                     host_sep_strobes,
  input  wire logic                     host_mem_select,
  input  wire logic                     chip_select_n,
  input  wire logic                     data_or_read_strobe,
  input  wire logic                     rw_or_write_n,
  input  wire logic                     addr_latch_strobe,
  input  wire logic [7:0]               host_addr_lines,
  input  wire logic [7:0]               host_low_byte_lines_in,
  output logic      [7:0]               host_low_byte_lines_out,
  output logic                          host_low_byte_lines_oe,
  input  wire logic [7:0]               host_high_byte_lines_in,
  output logic      [7:0]               host_high_byte_lines_out,
  output logic                          host_high_byte_lines_oe,
  output logic                          transfer_ack_n,
  output logic                          transfer_ack_oe
);
  localparam int SW = $clog2(NS);
  localparam int AW = SW + 5;

  typedef struct packed {
    logic                   sclk_q;
    logic                   sclk_div;
    logic                   idle_lvl;
    logic                   fs_prev;
    logic [7:0]             bit_cnt;
    logic                   frame_bank;
    logic [NS-1:0][7:0]     in_sr;
    logic [NS-1:0][7:0]     pend;
    logic [NS-1:0][4:0]     pend_ch;
    logic [NS-1:0]          pend_bank;
    logic [NS-1:0]          pend_mask;
    logic [NS-1:0][7:0]     out_sr;
    logic [NS-1:0]          out_hiz;
    logic [NS-1:0][7:0]     nxt_data;
    logic [NS-1:0]          nxt_hiz;
    logic                   fetch_busy;
    logic [SW-1:0]          fidx;
    logic [4:0]             nch;
    logic [7:0]             addr_lat;
    logic                   act_q;
    tsi_pkg::tsi_ack_t      ack_st;
    logic [15:0]            rd_data;
    logic                   rd_oe;
    logic                   blk_busy;
    logic [7:0]             blk_addr;
    logic                   ev_arm;
    logic                   ev_busy;
    logic [8:0]             ev_cnt;
    logic [8:0]             ev_result;
    logic                   ev_done;
  } tsi_state_t;

  tsi_state_t s;
  tsi_state_t next_s;

  logic [tsi_pkg::CM_W-1:0] cmem [2**AW];
  logic [7:0]               dmem [2**(AW+1)];

  logic                     cm_we;
  logic [AW-1:0]            cm_wa;
  logic [tsi_pkg::CM_W-1:0] cm_wd;
  logic                     dm_we;
  logic [AW:0]              dm_wa;
  logic [7:0]               dm_wd;
  logic                     rise;
  logic                     bit_stb;
  logic                     fs_act;
  logic                     frm_start;
  logic                     wr_found;
  logic [7:0]               pos;
  logic [tsi_pkg::CM_W-1:0] cm_rd;
  logic                     rd_bank;
  logic                     sep;
  logic                     strobe_on;
  logic                     act;
  logic                     is_rd;
  logic [7:0]               haddr;

  // Bit position of a stream once its own frame offset is taken off
  function automatic logic [7:0] tsi_in_pos(input logic [7:0]       b,
                                            input logic [OFS_W-1:0] o);
    return 8'(b - 8'(o));
  endfunction

  always_comb begin
    next_s    = s;
    cm_we     = 1'b0;
    cm_wa     = '0;
    cm_wd     = '0;
    dm_we     = 1'b0;
    dm_wa     = '0;
    dm_wd     = '0;
    wr_found  = 1'b0;
    pos       = '0;
    cm_rd     = '0;
    rd_bank   = 1'b0;
    // Serial clock runs at twice the bit rate
    rise      = serial_clk & ~s.sclk_q;
    bit_stb   = rise & (s.sclk_div == 1'(tsi_pkg::SCLK_PER_BIT - 1));
    fs_act    = frame_sync_in != s.idle_lvl;
    frm_start = bit_stb & fs_act & ~s.fs_prev;
    next_s.sclk_q = serial_clk;
    if (rise) begin
      next_s.sclk_div = bit_stb ? 1'b0 : 1'b1;
    end

    // Frame counter; idle level learned mid-frame gives the sync polarity
    if (bit_stb) begin
      next_s.fs_prev = fs_act;
      if (s.bit_cnt == tsi_pkg::FS_LEARN_BIT) begin
        next_s.idle_lvl = frame_sync_in;
      end
      if (frm_start) begin
        next_s.bit_cnt    = tsi_pkg::BIT_CNT_RST;
        next_s.frame_bank = ~s.frame_bank;
      end else begin
        next_s.bit_cnt = 8'(s.bit_cnt + 8'h01);
      end
    end

    // Drain one finished input byte per core cycle into data memory
    for (int i = 0; i < NS; i++) begin
      if (s.pend_mask[i] && !wr_found) begin
        wr_found            = 1'b1;
        dm_we               = 1'b1;
        dm_wa               = {s.pend_bank[i], SW'(i), s.pend_ch[i]};
        dm_wd               = s.pend[i];
        next_s.pend_mask[i] = 1'b0;
      end
    end

    // Input shift and output shift per stream, MSB first
    for (int i = 0; i < NS; i++) begin
      if (bit_stb) begin
        pos = tsi_in_pos(s.bit_cnt, stream_offsets[i]);
        next_s.in_sr[i] = {s.in_sr[i][6:0], serial_in_streams[i]};
        if (pos[2:0] == 3'h7) begin
          // Set after the drain so a new byte is never dropped
          next_s.pend[i]      = {s.in_sr[i][6:0], serial_in_streams[i]};
          next_s.pend_ch[i]   = pos[7:3];
          next_s.pend_bank[i] = s.frame_bank;
          next_s.pend_mask[i] = 1'b1;
        end
        if (s.bit_cnt[2:0] == 3'h7) begin
          next_s.out_sr[i]  = s.nxt_data[i];
          next_s.out_hiz[i] = s.nxt_hiz[i];
        end else begin
          next_s.out_sr[i] = {s.out_sr[i][6:0], 1'b0};
        end
      end
    end

    // Fetch the following channel one slot ahead, one stream per cycle
    if (bit_stb && s.bit_cnt[2:0] == 3'h0) begin
      next_s.fetch_busy = 1'b1;
      next_s.fidx       = '0;
      next_s.nch        = 5'(s.bit_cnt[7:3] + 5'h01);
    end
    if (s.fetch_busy) begin
      cm_rd = cmem[{s.fidx, s.nch}];
      // Constant delay always reads the last complete frame; variable
      // delay takes this frame's byte once it has arrived
      rd_bank = (cm_rd[tsi_pkg::CM_CONST_BIT] ||
                 cm_rd[4:0] >= s.bit_cnt[7:3]) ? ~s.frame_bank : s.frame_bank;
      next_s.nxt_data[s.fidx] = cm_rd[tsi_pkg::CM_PROC_BIT]
                              ? cm_rd[tsi_pkg::SRC_LSB +: tsi_pkg::SRC_W]
                              : dmem[{rd_bank, cm_rd[AW-1:0]}];
      next_s.nxt_hiz[s.fidx]  = cm_rd[tsi_pkg::CM_HIZ_BIT];
      next_s.fidx             = SW'(s.fidx + 1'b1);
      if (s.fidx == SW'(NS - 1)) begin
        next_s.fetch_busy = 1'b0;
      end
    end

    // Host port strobe decoding for the three bus styles
    sep       = host_style_select & host_sep_strobes;
    strobe_on = sep ? (~data_or_read_strobe | ~rw_or_write_n)
              : host_style_select ? data_or_read_strobe
              : ~data_or_read_strobe;
    act       = ~chip_select_n & strobe_on;
    is_rd     = sep ? ~data_or_read_strobe : rw_or_write_n;
    haddr     = host_style_select ? s.addr_lat : host_addr_lines;
    next_s.act_q = act;
    if (host_style_select && addr_latch_strobe) begin
      next_s.addr_lat = host_low_byte_lines_in;
    end

    unique case (s.ack_st)
      tsi_pkg::ACK_IDLE: begin
      end
      tsi_pkg::ACK_LOW: begin
        if (!act) begin
          next_s.ack_st = tsi_pkg::ACK_HIGH;
          next_s.rd_oe  = 1'b0;
        end
      end
      tsi_pkg::ACK_HIGH: begin
        next_s.ack_st = tsi_pkg::ACK_IDLE;
      end
    endcase

    if (act && !s.act_q) begin
      next_s.ack_st = tsi_pkg::ACK_LOW;
      if (is_rd) begin
        next_s.rd_oe   = 1'b1;
        next_s.rd_data = host_mem_select
                       ? {8'h00, dmem[{~s.frame_bank, haddr[AW-1:0]}]}
                       : cmem[haddr[AW-1:0]];
      end else if (!host_mem_select) begin
        cm_we = 1'b1;
        cm_wa = haddr[AW-1:0];
        cm_wd = {host_high_byte_lines_in, host_low_byte_lines_in};
      end
    end

    // Block fill yields the write port to the host
    if (block_prog_start && !s.blk_busy) begin
      next_s.blk_busy = 1'b1;
      next_s.blk_addr = '0;
    end
    if (s.blk_busy && !cm_we) begin
      cm_we           = 1'b1;
      cm_wa           = s.blk_addr[AW-1:0];
      cm_wd           = block_prog_word;
      next_s.blk_addr = 8'(s.blk_addr + 8'h01);
      if (s.blk_addr == tsi_pkg::BLK_LAST_ADDR) begin
        next_s.blk_busy = 1'b0;
      end
    end

    // Frame offset measurement in serial clock rising edges from frame start
    if (eval_start) begin
      next_s.ev_arm  = 1'b1;
      next_s.ev_done = 1'b0;
    end
    if (s.ev_busy) begin
      if (frame_eval_in) begin
        next_s.ev_busy   = 1'b0;
        next_s.ev_result = s.ev_cnt;
        next_s.ev_done   = 1'b1;
      end else if (rise) begin
        next_s.ev_cnt = 9'(s.ev_cnt + 9'h001);
      end
    end else if (s.ev_arm && frm_start) begin
      next_s.ev_arm  = 1'b0;
      next_s.ev_busy = 1'b1;
      next_s.ev_cnt  = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s          <= '0;
      s.idle_lvl <= tsi_pkg::IDLE_LVL_RST;
      s.ack_st   <= tsi_pkg::ACK_IDLE;
      s.out_hiz  <= '1;
      s.nxt_hiz  <= '1;
    end else begin
      s <= next_s;
    end
  end

  // Memories hold no reset; software must program before enabling outputs
  always_ff @(posedge core_clk) begin
    if (cm_we) begin
      cmem[cm_wa] <= cm_wd;
    end
    if (dm_we) begin
      dmem[dm_wa] <= dm_wd;
    end
  end

  always_comb begin
    for (int i = 0; i < NS; i++) begin
      serial_out_streams[i] = s.out_sr[i][7];
    end
  end

  assign serial_out_oe            = {NS{reset_n & serial_drive_enable}} & ~s.out_hiz;
  assign frame_format_gci         = ~s.idle_lvl;
  assign eval_done                = s.ev_done;
  assign eval_result              = s.ev_result;
  assign block_prog_busy          = s.blk_busy;
  assign host_low_byte_lines_out  = s.rd_data[7:0];
  assign host_high_byte_lines_out = s.rd_data[15:8];
  assign host_low_byte_lines_oe   = reset_n & s.rd_oe;
  assign host_high_byte_lines_oe  = reset_n & s.rd_oe;
  assign transfer_ack_n           = s.ack_st != tsi_pkg::ACK_LOW;
  assign transfer_ack_oe          = reset_n & (s.ack_st != tsi_pkg::ACK_IDLE);
endmodule

// ===== verif/tb_time_slot_interchange_switch.sv
// Purpose: Self-checking bench for the slot switch
// Assumes: Partner streams carry a constant level per stream
// Notes:   Whole-frame waits keep serial checks free of bit phase
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_time_slot_interchange_switch;
  logic        core_clk;
  logic        reset_n;
  logic        serial_clk;
  logic [7:0]  sin;
  logic [7:0]  sout;
  logic [7:0]  sout_oe;
  logic        sde;
  logic        fsync;
  logic        gci;
  logic        feval;
  logic        eval_start;
  logic        eval_done;
  logic [8:0]  eval_result;
  logic        bp_start;
  logic [15:0] bp_word;
  logic        bp_busy;
  logic        mux;
  logic        sep;
  logic        msel;
  logic        cs_n;
  logic        ds;
  logic        rw;
  logic        ale;
  logic [7:0]  addr;
  logic [7:0]  lo_in;
  logic [7:0]  lo_out;
  logic [7:0]  hi_in;
  logic [7:0]  hi_out;
  logic        lo_oe;
  logic        hi_oe;
  logic [23:0] ofs;
  logic        ack_n;
  logic        ack_oe;
  logic [15:0] cm[256];
  logic [31:0] seed = 32'ha546a442;
  int          num_errors = 0;
  int          n_compared = 0;
  tsi_stream_partner i_tsi_stream_partner (.core_clk(core_clk), .serial_clk(serial_clk),
    .frame_sync_in(fsync), .frame_eval_in(feval), .serial_in_streams(sin));
  tsi_switch i_tsi_switch (.core_clk(core_clk), .reset_n(reset_n), .serial_clk(serial_clk),
    .serial_in_streams(sin), .serial_out_streams(sout), .serial_out_oe(sout_oe),
    .serial_drive_enable(sde), .frame_sync_in(fsync), .frame_format_gci(gci),
    .frame_eval_in(feval), .eval_start(eval_start), .eval_done(eval_done),
    .eval_result(eval_result), .stream_offsets(ofs), .block_prog_start(bp_start),
    .block_prog_word(bp_word), .block_prog_busy(bp_busy), .host_style_select(mux),
    .host_sep_strobes(sep), .host_mem_select(msel), .chip_select_n(cs_n),
    .data_or_read_strobe(ds), .rw_or_write_n(rw), .addr_latch_strobe(ale),
    .host_addr_lines(addr), .host_low_byte_lines_in(lo_in), .host_low_byte_lines_out(lo_out),
    .host_low_byte_lines_oe(lo_oe), .host_high_byte_lines_in(hi_in),
    .host_high_byte_lines_out(hi_out), .host_high_byte_lines_oe(hi_oe), .transfer_ack_n(ack_n),
    .transfer_ack_oe(ack_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Processor data or source stream level decides the whole byte
  function automatic logic [7:0] exp_byte(input logic [15:0] w);
    return (w[8] ? w[0] : w[5]) ? 8'hff : 8'h00;
  endfunction
  // m: 0 non-multiplexed, 1 multiplexed with direction, 2 separate strobes
  task automatic acc(input int m, input bit r, input logic [7:0] a, input logic [15:0] wd,
                     output logic [15:0] q);
    int n;
    @(negedge core_clk);
    {mux, sep, addr, ale, lo_in} = {m != 0, m == 2, a, m != 0, a};
    @(negedge core_clk);
    {ale, lo_in, hi_in, cs_n, rw} = {1'b0, wd[7:0], wd[15:8], 1'b0, r};
    ds = (m == 2) ? !r : (m == 1);
    n = 0;
    // Sampled off the launching edge so the registered answer has settled
    do begin
      @(negedge core_clk);
      n++;
    end while (ack_n !== 1'b0 && n < 20);
    q = {hi_out, lo_out};
    `CHK("ack", 1'b1, n < 20)
    `CHK("data_oe", {r, r}, {lo_oe, hi_oe})
    @(negedge core_clk);
    {cs_n, ds, rw} = {1'b1, m != 1, 1'b1};
    repeat (3) @(negedge core_clk);
  endtask
  task automatic fill(input logic [15:0] w);
    int n;
    @(negedge core_clk);
    {bp_word, bp_start} = {w, 1'b1};
    @(negedge core_clk);
    bp_start = 1'b0;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (bp_busy !== 1'b0 && n < 600);
    `CHK("fill", 1'b1, n < 600)
    foreach (cm[i]) cm[i] = w;
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = !core_clk;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    finish_test();
  end
  initial begin
    logic [15:0] q;
    logic [7:0]  a;
    logic [15:0] words[$];
    int          n;
    words = '{16'h01ff, 16'h0020, 16'h0220, 16'h0000, 16'h0400};
    {reset_n, sde, eval_start, bp_start, bp_word, mux, sep, msel, ale} = '0;
    ofs = '0;
    {cs_n, ds, rw, addr, lo_in, hi_in} = {3'b111, 24'h000000};
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    `CHK("sout_oe", 8'h00, sout_oe)
    `CHK("gci", 1'b0, gci)
    $display("test reset done");
    fill(16'h01ff);
    for (int k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      a = seed[7:0];
      cm[a] = seed[23:8];
      acc(k % 3, 1'b0, a, cm[a], q);
      acc((k + 1) % 3, 1'b1, a, 16'h0000, q);
      `CHK("cmem", cm[a], q)
    end
    $display("test host styles done");
    @(negedge core_clk);
    {ds, rw, lo_in, hi_in} = {2'b00, ~cm[a]};
    repeat (4) @(negedge core_clk);
    `CHK("ack_oe", 1'b0, ack_oe)
    {ds, rw} = 2'b11;
    acc(0, 1'b1, a, 16'h0000, q);
    `CHK("cmem_kept", cm[a], q)
    $display("test chip select done");
    sde = 1'b1;
    // Random per-stream offsets must not disturb whole-byte routing
    seed = lfsr(seed);
    ofs = seed[23:0];
    foreach (words[i]) begin
      fill(words[i]);
      repeat (12800) @(negedge core_clk);
      `CHK("sout_oe", words[i][10] ? 8'h00 : 8'hff, sout_oe)
      if (!words[i][10])
        `CHK("sout", exp_byte(words[i]), sout)
    end
    `CHK("gci", 1'b1, gci)
    $display("test serial done");
    msel = 1'b1;
    for (int s = 2; s < 4; s++) begin
      acc(s - 2, 1'b1, 8'(s * 32 + 5), 16'h0000, q);
      `CHK("dmem", {8'h00, (s % 2) ? 8'hff : 8'h00}, q)
    end
    @(negedge core_clk);
    eval_start = 1'b1;
    @(negedge core_clk);
    eval_start = 1'b0;
    n = 0;
    while (eval_done !== 1'b1 && n < 26000) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("eval", 1'b1, eval_done === 1'b1 && eval_result >= 9'd96 && eval_result <= 9'd104)
    $display("test memory and eval done");
    finish_test();
  end
endmodule

// ===== verif/tsi_stream_partner.sv
// Purpose: Far-side streams, frame pulse and evaluation input
// Assumes: Driven on falling core edges, clock near 4.096 MHz
// Notes:   Stream i holds level i[0] so bytes need no bit alignment
`timescale 1ns/100ps
module tsi_stream_partner #(
  parameter int HALF    = 12,
  parameter bit GCI     = 1'b1,
  parameter int EVAL_AT = 100
) (
  input  wire logic  core_clk,
  output logic       serial_clk,
  output logic       frame_sync_in,
  output logic       frame_eval_in,
  output logic [7:0] serial_in_streams
);
  int cyc = 0;
  int rises = 0;
  initial begin
    serial_clk = 1'b0;
    frame_sync_in = !GCI;
    frame_eval_in = 1'b0;
    serial_in_streams = 8'haa;
  end
  // Backplane clock runs free, frames follow back to back
  always @(negedge core_clk) begin
    cyc <= (cyc == HALF - 1) ? 0 : cyc + 1;
    if (cyc == HALF - 1) begin
      serial_clk <= !serial_clk;
      if (!serial_clk) begin
        rises <= (rises == 511) ? 0 : rises + 1;
        frame_sync_in <= (rises < 2) ? GCI : !GCI;
        frame_eval_in <= (rises >= EVAL_AT) && (rises < EVAL_AT + 4);
      end
    end
  end
endmodule

// ===== verif/tsi_switch_assertions.sv
// Purpose: Port-level checks for the slot switch
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Host activity is rebuilt from the strobes of each style
`timescale 1ns/100ps
module tsi_switch_checker #(
  parameter int NS = 8
) (
  input wire logic          core_clk,
  input wire logic          reset_n,
  input wire logic          serial_clk,
  input wire logic [NS-1:0] serial_out_streams,
  input wire logic [NS-1:0] serial_out_oe,
  input wire logic          serial_drive_enable,
  input wire logic          block_prog_start,
  input wire logic          block_prog_busy,
  input wire logic          host_style_select,
  input wire logic          host_sep_strobes,
  input wire logic          chip_select_n,
  input wire logic          data_or_read_strobe,
  input wire logic          rw_or_write_n,
  input wire logic          host_low_byte_lines_oe,
  input wire logic          transfer_ack_n,
  input wire logic          transfer_ack_oe
);
  logic       sep;
  logic       act;
  logic       rd;
  logic       sclk_q;
  logic [3:0] age;
  assign sep = host_style_select & host_sep_strobes;
  assign act = !chip_select_n & (sep ? !(data_or_read_strobe & rw_or_write_n)
             : (host_style_select ? data_or_read_strobe : !data_or_read_strobe));
  assign rd  = sep ? !data_or_read_strobe : rw_or_write_n;
  // Cycles since the last serial clock rise, saturating so it never wraps
  always_ff @(posedge core_clk) begin
    sclk_q <= serial_clk;
    age    <= !reset_n ? 4'hf : (serial_clk & !sclk_q) ? 4'h0 : (age == 4'hf) ? age : age + 4'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  AST_RESET_FLOAT: assert property (!reset_n |-> serial_out_oe == '0
    && !transfer_ack_oe && !host_low_byte_lines_oe) else $error("outputs driven in reset");
  AST_CS_GATE: assert property (disable iff (!reset_n) $rose(transfer_ack_oe)
    |-> !$past(chip_select_n)) else $error("acknowledge without chip select");
  AST_ACK_TAKEN: assert property (disable iff (!reset_n) $rose(act)
    |=> !transfer_ack_n && transfer_ack_oe) else $error("no acknowledge after strobe");
  AST_ACK_STAND: assert property (disable iff (!reset_n) !transfer_ack_n && act
    |=> !transfer_ack_n && transfer_ack_oe) else $error("acknowledge dropped early");
  AST_ACK_END: assert property (disable iff (!reset_n) !transfer_ack_n && !act
    |=> (transfer_ack_n && transfer_ack_oe) ##1 (!transfer_ack_oe || !transfer_ack_n))
    else $error("acknowledge not released");
  AST_READ_DRIVE: assert property (disable iff (!reset_n) $rose(act) && rd
    |=> host_low_byte_lines_oe) else $error("read did not drive data");
  AST_WRITE_FLOAT: assert property (disable iff (!reset_n) $rose(act) && !rd
    |=> !host_low_byte_lines_oe) else $error("write drove data");
  AST_DATA_IN_ACK: assert property (disable iff (!reset_n) host_low_byte_lines_oe
    |-> !transfer_ack_n) else $error("data driven outside acknowledge");
  AST_SERIAL_OFF: assert property (disable iff (!reset_n) !serial_drive_enable
    |-> serial_out_oe == '0) else $error("serial driven while disabled");
  AST_BIT_PACE: assert property (disable iff (!reset_n) !$stable(serial_out_streams)
    |-> age <= 4'h4) else $error("serial bit changed off strobe");
  AST_FILL_START: assert property (disable iff (!reset_n) block_prog_start
    && !block_prog_busy |-> ##[1:2] block_prog_busy) else $error("fill not started");
  AST_FILL_SPAN: assert property (disable iff (!reset_n) $rose(block_prog_busy)
    |-> ##250 block_prog_busy ##[1:700] !block_prog_busy) else $error("fill length wrong");
endmodule
bind tsi_switch tsi_switch_checker #(.NS(NS)) i_tsi_switch_checker (
  .core_clk(core_clk), .reset_n(reset_n), .serial_clk(serial_clk),
  .serial_out_streams(serial_out_streams), .serial_out_oe(serial_out_oe),
  .serial_drive_enable(serial_drive_enable), .block_prog_start(block_prog_start),
  .block_prog_busy(block_prog_busy), .host_style_select(host_style_select),
  .host_sep_strobes(host_sep_strobes), .chip_select_n(chip_select_n),
  .data_or_read_strobe(data_or_read_strobe), .rw_or_write_n(rw_or_write_n),
  .host_low_byte_lines_oe(host_low_byte_lines_oe), .transfer_ack_n(transfer_ack_n),
  .transfer_ack_oe(transfer_ack_oe));
